// ===== pkg/cblme_defs.svh
// Constants of the branch, call, load and move execution block.
// Notes on behaviour
// RQ1 - Immediate AND zero-extends the 9-bit immediate and ANDs it into the destination.
// RQ2 - Register-tested branches jump on zero or nonzero; displacement is 9 bits, not 13.
// RQ3 - Flag-tested branches jump on flag zero or nonzero, else sequence normally.
// RQ4 - Every transfer has exactly one delay slot that always executes.
// RQ5 - Clear-flag selector: 0 condition flag, 1 high-address select, 2 interrupt enable.
// RQ6 - Conditional add-immediate adds the zero-extended immediate only when the flag is one.
// RQ7 - Conditional subtract-immediate subtracts the zero-extended immediate when the flag is one.
// RQ8 - Relative jump always loads program counter plus displacement.
// RQ9 - Call via register jumps to the source and links past the delay slot.
// RQ10 - Windowed register call raises the window level and links into the new window.
// RQ11 - Windowed relative call raises the window level, links, then jumps relative.
// RQ12 - Code reached by a windowed call holds an instruction and ends in a return.
// RQ13 - Register goto loads the source register and leaves the window level alone.
// RQ14 - Windowed return loads the source register and lowers the window level.
// RQ15 - Full-word load joins two 9-bit words, lower address in the upper half.
// RQ16 - Software gives full-word loads an even effective address.
// RQ17 - Half-word load accepts any address and zero-extends the 9-bit word.
// RQ18 - Load upper immediate puts the immediate in bits 17 to 9, clearing the rest.
// RQ19 - Register copy writes all 18 source bits to the destination.
// RQ20 - Move immediate writes the zero-extended 9-bit immediate to the destination.
// RQ21 - Special register write copies the source into the indexed special register.
// RQ22 - A window change by special register write takes effect after the next instruction.
// RQ23 - Window level starts at 0 and rises by calls up to 126.
// RQ24 - High-address select lets address bit 17 reach the memory; the core gates it on data load addresses only, not on fetches.
// RQ25 - Interrupt enable zero disables hardware interrupts, one enables them.
// RQ26 - Relative displacements are signed and added to the transfer's own address.
`ifndef CBLME_DEFS_SVH
`define CBLME_DEFS_SVH

`define CBLME_OP_SPEC1    5'h00
`define CBLME_OP_SPEC2    5'h01
`define CBLME_OP_J        5'h02
`define CBLME_OP_JALS     5'h03
`define CBLME_OP_BEQZ     5'h04
`define CBLME_OP_BNEZ     5'h05
`define CBLME_OP_BEQZC    5'h06
`define CBLME_OP_BNEZC    5'h07
`define CBLME_OP_MOVI     5'h09
`define CBLME_OP_LHI      5'h0A
`define CBLME_OP_ANDI     5'h0C
`define CBLME_OP_L9       5'h10
`define CBLME_OP_L18      5'h12
`define CBLME_OP_IFADDUI  5'h1E
`define CBLME_OP_IFSUBUI  5'h1F

`define CBLME_F1_MOV      5'h05
`define CBLME_F1_CBITS    5'h16
`define CBLME_F1_SBITS    5'h17
`define CBLME_F2_JR       5'h02
`define CBLME_F2_JALR     5'h03
`define CBLME_F2_JRS      5'h04
`define CBLME_F2_JALRS    5'h05
`define CBLME_F2_WRITE_SPECIAL_REGISTER   5'h1E

`define CBLME_SEL_COND    4'h0
`define CBLME_SEL_HIADDR  4'h1
`define CBLME_SEL_IE      4'h2
`define CBLME_SFR_STATE   4'h0
`define CBLME_SFR_COND    4'h3

`define CBLME_LINK_REG    4'hB
`define CBLME_GLOBAL_REGS 4'h4
`define CBLME_WIN_MAX     7'h7E
`define CBLME_WIN_MIN     7'h00
`define CBLME_RF_DEPTH    1024
`define CBLME_ADDR_BIT17  17

`define CBLME_REG_CTRL    4'h0
`define CBLME_REG_STATE   4'h4
`define CBLME_REG_COND    4'h8
`define CBLME_REG_PC      4'hC

`define CBLME_PC_RESET    18'h00000
`define CBLME_NPC_RESET   18'h00001
`define CBLME_PC_STEP     18'h00001
`define CBLME_LINK_STEP   18'h00002
`define CBLME_LD_STEP     18'h00001

`endif

// ===== pkg/cblme_pkg.sv
// Types shared by the branch, call, load and move execution block.
package cblme_pkg;

	typedef enum logic [2:0] {
		ST_FETCH  = 3'h0,
		ST_WAIT   = 3'h1,
		ST_EXEC   = 3'h3,
		ST_LOAD_A = 3'h2,
		ST_LOAD_B = 3'h6,
		ST_LOAD_C = 3'h7
	} cblme_state_t;

	typedef enum logic [1:0] {
		LD_NONE = 2'h0,
		LD_HALF = 2'h1,
		LD_FULL = 2'h2
	} cblme_load_t;

	typedef struct packed {
		logic       interrupt_enable;
		logic       high_addr_select;
		logic [6:0] window_level;
	} cblme_status_t;

	typedef struct packed {
		logic        wr;
		logic [3:0]  idx;
		logic [17:0] data;
	} cblme_sfr_t;

endpackage

// ===== verilog/cblme_core.sv
// Execution core for branches, calls, loads, moves and special register writes.
//
// Local design decisions: the strobed register port and the register addresses.
`include "cblme_defs.svh"

module cblme_core (
	// Clock and reset.
	input  wire logic                    clk_sys_i,
	input  wire logic                    resetn_i,
	// Register port.
	input  wire logic [3:0]              reg_addr_i,
	input  wire logic [31:0]             reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic [31:0]                  reg_rdata_o,
	// Instruction memory.
	output logic [17:0]                  imem_addr_o,
	output logic                         imem_rd_o,
	input  wire logic [17:0]             imem_data_i,
	// Data memory.
	output logic [17:0]                  dmem_addr_o,
	output logic                         dmem_rd_o,
	input  wire logic [8:0]              dmem_data_i,
	// Special registers and state.
	output cblme_pkg::cblme_sfr_t        sfr_o,
	output cblme_pkg::cblme_status_t     status_o,
	output logic                         condition_flag_o,
	output logic                         unsupported_o
);
	import cblme_pkg::*;

	cblme_state_t  state_reg;
	cblme_status_t status_reg;
	cblme_sfr_t    sfr_reg;
	cblme_load_t   ld_kind_reg;
	logic [17:0]   pc_reg;
	logic [17:0]   npc_reg;
	logic [17:0]   rf_mem [0:`CBLME_RF_DEPTH-1];
	logic          cc_reg;
	logic          run_reg;
	logic          pend_reg;
	logic [6:0]    win_pend_reg;
	logic [9:0]    ld_widx_reg;
	logic [17:0]   ld_addr_reg;
	logic [8:0]    ld_hi_reg;
	logic [31:0]   rdata_reg;
	logic          unsup_reg;

	logic        ex;
	logic [4:0]  op;
	logic [4:0]  fn;
	logic [3:0]  f_a;
	logic [3:0]  f_b;
	logic [8:0]  imm9;
	logic [17:0] imm_z;
	logic [17:0] a_val;
	logic [17:0] b_val;
	logic [17:0] br9_target;
	logic [17:0] j13_target;
	logic [6:0]  win_up;
	logic [6:0]  win_down;
	logic [17:0] ld_addr;
	logic        done;

	logic          x_we;
	logic [9:0]    x_widx;
	logic [17:0]   x_wdata;
	logic          x_taken;
	logic [17:0]   x_target;
	cblme_load_t   x_load;
	logic          x_win_set;
	logic [6:0]    x_win_val;
	logic          x_cc_we;
	logic          x_cc_val;
	logic          x_st_we;
	cblme_status_t x_st_val;
	logic          x_sfr_we;
	logic          x_unsup;

	function automatic logic [9:0] rf_index(input logic [3:0] r, input logic [6:0] w);
		if (r < `CBLME_GLOBAL_REGS)
			return {6'h0, r};
		return {w, 3'h0} + {6'h0, r};
	endfunction

	assign ex         = (state_reg == ST_EXEC);
	assign op         = imem_data_i[17:13];
	assign fn         = imem_data_i[4:0];
	assign f_a        = imem_data_i[12:9];
	assign f_b        = imem_data_i[8:5];
	assign imm9       = imem_data_i[8:0];
	assign imm_z      = {9'h0, imm9};
	assign a_val      = rf_mem[rf_index(f_a, status_reg.window_level)];
	assign b_val      = rf_mem[rf_index(f_b, status_reg.window_level)];
	// Signed displacements taken from the transfer's own address. [RQ26]
	assign br9_target = pc_reg + {{9{imm9[8]}}, imm9}; // [RQ2]
	assign j13_target = pc_reg + {{5{imem_data_i[12]}}, imem_data_i[12:0]};
	// The level saturates so a runaway call chain cannot wrap into window zero.
	assign win_up     = (status_reg.window_level == `CBLME_WIN_MAX) ?
	                    status_reg.window_level : status_reg.window_level + 7'h1; // [RQ23]
	assign win_down   = (status_reg.window_level == `CBLME_WIN_MIN) ?
	                    status_reg.window_level : status_reg.window_level - 7'h1;
	assign ld_addr    = b_val + {13'h0, fn}; // [RQ15] [RQ17]
	assign done       = (ex && x_load == LD_NONE) ||
	                    (state_reg == ST_LOAD_B && ld_kind_reg == LD_HALF) ||
	                    (state_reg == ST_LOAD_C);

	always_comb begin
		x_we      = 1'b0;
		x_widx    = rf_index(f_a, status_reg.window_level);
		x_wdata   = a_val;
		x_taken   = 1'b0;
		x_target  = j13_target;
		x_load    = LD_NONE;
		x_win_set = 1'b0;
		x_win_val = status_reg.window_level;
		x_cc_we   = 1'b0;
		x_cc_val  = cc_reg;
		x_st_we   = 1'b0;
		x_st_val  = status_reg;
		x_sfr_we  = 1'b0;
		x_unsup   = 1'b0;
		if (ex) begin
			case (op)
				`CBLME_OP_ANDI: begin
					x_we    = 1'b1;
					x_wdata = a_val & imm_z; // [RQ1]
				end
				`CBLME_OP_BEQZ, `CBLME_OP_BNEZ: begin
					x_target = br9_target;
					x_taken  = (op == `CBLME_OP_BEQZ) ? (a_val == 18'h0) : (a_val != 18'h0); // [RQ2]
				end
				`CBLME_OP_BEQZC: x_taken = !cc_reg; // [RQ3]
				`CBLME_OP_BNEZC: x_taken = cc_reg; // [RQ3]
				`CBLME_OP_IFADDUI: begin
					x_we    = cc_reg; // [RQ6]
					x_wdata = a_val + imm_z;
				end
				`CBLME_OP_IFSUBUI: begin
					x_we    = cc_reg;
					x_wdata = a_val - imm_z; // [RQ7]
				end
				`CBLME_OP_J: x_taken = 1'b1; // [RQ8]
				`CBLME_OP_JALS: begin
					x_taken   = 1'b1; // [RQ11]
					x_win_set = 1'b1;
					x_win_val = win_up;
					x_we      = 1'b1;
					x_widx    = rf_index(`CBLME_LINK_REG, win_up);
					x_wdata   = pc_reg + `CBLME_LINK_STEP;
				end
				`CBLME_OP_L9, `CBLME_OP_L18: begin
					x_load = (op == `CBLME_OP_L9) ? LD_HALF : LD_FULL;
				end
				`CBLME_OP_LHI: begin
					x_we    = 1'b1;
					x_wdata = {imm9, 9'h0}; // [RQ18]
				end
				`CBLME_OP_MOVI: begin
					x_we    = 1'b1;
					x_wdata = imm_z; // [RQ20]
				end
				`CBLME_OP_SPEC1: begin
					case (fn)
						`CBLME_F1_MOV: begin
							x_we    = 1'b1;
							x_wdata = b_val; // [RQ19]
						end
						`CBLME_F1_CBITS, `CBLME_F1_SBITS: begin
							// Selector decode for clearing and setting. [RQ5]
							case (f_b)
								`CBLME_SEL_COND: begin
									x_cc_we  = 1'b1;
									x_cc_val = fn[0];
								end
								`CBLME_SEL_HIADDR: begin
									x_st_we                   = 1'b1;
									x_st_val.high_addr_select = fn[0]; // [RQ24]
								end
								`CBLME_SEL_IE: begin
									x_st_we                   = 1'b1;
									x_st_val.interrupt_enable = fn[0]; // [RQ25]
								end
								default: x_unsup = 1'b1;
							endcase
						end
						default: x_unsup = 1'b1;
					endcase
				end
				`CBLME_OP_SPEC2: begin
					x_target = b_val;
					case (fn)
						`CBLME_F2_JR: x_taken = 1'b1; // [RQ13]
						`CBLME_F2_JALR: begin
							x_taken = 1'b1; // [RQ9]
							x_we    = 1'b1;
							x_widx  = rf_index(`CBLME_LINK_REG, status_reg.window_level);
							x_wdata = pc_reg + `CBLME_LINK_STEP;
						end
						`CBLME_F2_JRS: begin
							x_taken   = 1'b1; // [RQ14]
							x_win_set = 1'b1;
							x_win_val = win_down;
						end
						`CBLME_F2_JALRS: begin
							x_taken   = 1'b1; // [RQ10]
							x_win_set = 1'b1;
							x_win_val = win_up;
							x_we      = 1'b1;
							x_widx    = rf_index(`CBLME_LINK_REG, win_up);
							x_wdata   = pc_reg + `CBLME_LINK_STEP;
						end
						`CBLME_F2_WRITE_SPECIAL_REGISTER: begin
							x_sfr_we = 1'b1; // [RQ21]
							if (f_b == `CBLME_SFR_COND) begin
								x_cc_we  = 1'b1;
								x_cc_val = a_val[0];
							end
							if (f_b == `CBLME_SFR_STATE) begin
								x_st_we                   = 1'b1;
								x_st_val.interrupt_enable = a_val[8];
								x_st_val.high_addr_select = a_val[7];
								x_win_set                 = 1'b1; // [RQ22]
								x_win_val                 = a_val[6:0];
							end
						end
						default: x_unsup = 1'b1;
					endcase
				end
				default: x_unsup = 1'b1;
			endcase
		end
	end

	// Sequencer: fetch, wait for the word, execute, then optional load beats.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			state_reg <= ST_FETCH;
		end else begin
			case (state_reg)
				ST_FETCH:  state_reg <= run_reg ? ST_WAIT : ST_FETCH;
				ST_WAIT:   state_reg <= ST_EXEC;
				ST_EXEC:   state_reg <= (x_load == LD_NONE) ? ST_FETCH : ST_LOAD_A;
				ST_LOAD_A: state_reg <= ST_LOAD_B;
				ST_LOAD_B: state_reg <= (ld_kind_reg == LD_FULL) ? ST_LOAD_C : ST_FETCH;
				ST_LOAD_C: state_reg <= ST_FETCH;
				default:   state_reg <= ST_FETCH;
			endcase
		end
	end

	// The delay slot falls out of the two-deep counter pair. [RQ4]
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			pc_reg      <= `CBLME_PC_RESET;
			npc_reg     <= `CBLME_NPC_RESET;
			imem_addr_o <= `CBLME_PC_RESET;
			imem_rd_o   <= 1'b0;
		end else begin
			imem_rd_o <= (state_reg == ST_FETCH) && run_reg;
			if (state_reg == ST_FETCH)
				imem_addr_o <= pc_reg;
			if (ex) begin
				pc_reg  <= npc_reg; // [RQ4]
				npc_reg <= x_taken ? x_target : npc_reg + `CBLME_PC_STEP;
			end
		end
	end

	// Data loads; a full-word read takes the second word at the next address.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			dmem_addr_o <= `CBLME_PC_RESET;
			dmem_rd_o   <= 1'b0;
			ld_kind_reg <= LD_NONE;
			ld_widx_reg <= 10'h0;
			ld_addr_reg <= `CBLME_PC_RESET;
			ld_hi_reg   <= 9'h0;
		end else begin
			dmem_rd_o <= 1'b0;
			if (ex && x_load != LD_NONE) begin
				ld_kind_reg <= x_load;
				ld_widx_reg <= x_widx;
				ld_addr_reg <= ld_addr;
				dmem_rd_o   <= 1'b1;
				dmem_addr_o <= ld_addr;
				// Bit 17 reaches memory only with high-address select on. [RQ24]
				dmem_addr_o[`CBLME_ADDR_BIT17] <= ld_addr[`CBLME_ADDR_BIT17] &
				                                  status_reg.high_addr_select;
			end
			if (state_reg == ST_LOAD_A && ld_kind_reg == LD_FULL) begin
				// An odd address is software's fault; the carry is left to ripple. [RQ16]
				dmem_rd_o   <= 1'b1;
				dmem_addr_o <= dmem_addr_o + `CBLME_LD_STEP;
			end
			if (state_reg == ST_LOAD_B)
				ld_hi_reg <= dmem_data_i;
		end
	end

	// Register file write port shared by execution and load completion.
	always_ff @(posedge clk_sys_i) begin
		if (x_we)
			rf_mem[x_widx] <= x_wdata;
		else if (state_reg == ST_LOAD_B && ld_kind_reg == LD_HALF)
			rf_mem[ld_widx_reg] <= {9'h0, dmem_data_i}; // [RQ17]
		else if (state_reg == ST_LOAD_C)
			rf_mem[ld_widx_reg] <= {ld_hi_reg, dmem_data_i}; // [RQ15]
	end

	// Window level changes by instructions wait for the end of the following instruction; register port writes apply at once.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			status_reg   <= '0;
			pend_reg     <= 1'b0;
			win_pend_reg <= `CBLME_WIN_MIN;
		end else begin
			if (x_st_we)
				status_reg <= x_st_val;
			else if (reg_wr_i && reg_addr_i == `CBLME_REG_STATE)
				status_reg <= reg_wdata_i[8:0];
			if (done) begin
				if (pend_reg)
					status_reg.window_level <= win_pend_reg; // [RQ22]
				pend_reg     <= x_win_set;
				win_pend_reg <= x_win_val;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			cc_reg <= 1'b0;
		end else if (x_cc_we) begin
			cc_reg <= x_cc_val; // [RQ5]
		end else if (reg_wr_i && reg_addr_i == `CBLME_REG_COND) begin
			cc_reg <= reg_wdata_i[0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			sfr_reg   <= '0;
			unsup_reg <= 1'b0;
		end else begin
			sfr_reg.wr   <= x_sfr_we; // [RQ21]
			unsup_reg    <= x_unsup;
			if (x_sfr_we) begin
				sfr_reg.idx  <= f_b;
				sfr_reg.data <= a_val;
			end
		end
	end

	// Register port: run control, state word, flag and program counter.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			run_reg   <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			if (reg_wr_i && reg_addr_i == `CBLME_REG_CTRL)
				run_reg <= reg_wdata_i[0];
			rdata_reg <= 32'h0;
			if (reg_rd_i) begin
				case (reg_addr_i)
					`CBLME_REG_CTRL:  rdata_reg <= {31'h0, run_reg};
					`CBLME_REG_STATE: rdata_reg <= {23'h0, status_reg};
					`CBLME_REG_COND:  rdata_reg <= {31'h0, cc_reg};
					`CBLME_REG_PC:    rdata_reg <= {14'h0, pc_reg};
					default:          rdata_reg <= 32'h0;
				endcase
			end
		end
	end

	assign reg_rdata_o      = rdata_reg;
	assign sfr_o            = sfr_reg;
	assign status_o         = status_reg;
	assign condition_flag_o = cc_reg;
	assign unsupported_o    = unsup_reg;

	// Checks run in the single clock domain and sleep during reset.
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	sequence s_transfer;
		ex && x_taken;
	endsequence

	sequence s_window_armed;
		ex && x_win_set && !pend_reg;
	endsequence

	property p_andi_result;
		ex && op == `CBLME_OP_ANDI |=> rf_mem[$past(x_widx)] ==
		                               ($past(a_val) & {9'h0, $past(imm9)}) &&
		                               rf_mem[$past(x_widx)][17:9] == 9'h0;
	endproperty
	a_andi_result: assert property (p_andi_result) else $error("AND immediate wrong"); // [RQ1]

	property p_reg_branch;
		ex && op == `CBLME_OP_BNEZ && a_val == 18'h0 |=> npc_reg == $past(npc_reg) + 18'h1;
	endproperty
	a_reg_branch: assert property (p_reg_branch) else $error("untaken branch moved"); // [RQ2]

	property p_flag_branch;
		ex && op == `CBLME_OP_BEQZC && !cc_reg |=>
		npc_reg == $past(pc_reg) + {{5{$past(imem_data_i[12])}}, $past(imem_data_i[12:0])};
	endproperty
	a_flag_branch: assert property (p_flag_branch) else $error("flag branch missed"); // [RQ3]

	property p_delay_slot;
		s_transfer |=> pc_reg == $past(npc_reg) && npc_reg == $past(x_target);
	endproperty
	a_delay_slot: assert property (p_delay_slot) else $error("delay slot skipped"); // [RQ4]

	property p_clear_hiaddr;
		ex && op == `CBLME_OP_SPEC1 && fn == `CBLME_F1_CBITS && f_b == `CBLME_SEL_HIADDR
		|=> !status_reg.high_addr_select;
	endproperty
	a_clear_hiaddr: assert property (p_clear_hiaddr) else $error("select not cleared"); // [RQ5]

	property p_cond_add_hold;
		ex && op == `CBLME_OP_IFADDUI && !cc_reg |=> rf_mem[$past(x_widx)] == $past(a_val);
	endproperty
	a_cond_add_hold: assert property (p_cond_add_hold) else $error("register changed"); // [RQ6]

	property p_call_window;
		ex && op == `CBLME_OP_SPEC2 && fn == `CBLME_F2_JALRS && status_reg.window_level < 7'h7E
		|=> pend_reg && win_pend_reg == $past(status_reg.window_level) + 7'h1;
	endproperty
	a_call_window: assert property (p_call_window) else $error("window not raised"); // [RQ10]

	property p_window_wait;
		s_window_armed |=> status_reg.window_level == $past(status_reg.window_level);
	endproperty
	a_window_wait: assert property (p_window_wait) else $error("window moved early"); // [RQ22]

	property p_full_load;
		state_reg == ST_LOAD_C |=> rf_mem[$past(ld_widx_reg)] ==
		                          {$past(ld_hi_reg), $past(dmem_data_i)};
	endproperty
	a_full_load: assert property (p_full_load) else $error("full word wrong"); // [RQ15]

endmodule // cblme_core

// ===== test/cblme_mem_model.sv
// Behavioural instruction and data memory that answers one cycle after each strobe.
module cblme_mem_model (
	// Clock.
	input  wire logic        clk_sys_i,
	// Instruction side.
	input  wire logic [17:0] imem_addr_i,
	input  wire logic        imem_rd_i,
	output logic [17:0]      imem_data_o,
	// Data side.
	input  wire logic [17:0] dmem_addr_i,
	input  wire logic        dmem_rd_i,
	output logic [8:0]       dmem_data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [17:0] rom [0:511];
	logic [8:0]  ram [0:511];
	initial begin
		imem_data_o = 18'h00000;
		dmem_data_o = 9'h000;
	end
	// Between answers the lines flip so that a late sample never sees a stale word.
	always @(posedge clk_sys_i) begin
		imem_data_o <= imem_rd_i ? rom[imem_addr_i[8:0]] : ~imem_data_o;
		dmem_data_o <= dmem_rd_i ? ram[dmem_addr_i[8:0]] : ~dmem_data_o;
	end
endmodule // cblme_mem_model

// ===== test/tb.sv
// Self-checking bench that runs small programs through the execution core.
`include "cblme_defs.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cblme_pkg::*;
	logic          clk_sys_i, resetn_i, reg_wr_i, reg_rd_i, rd_d;
	logic [3:0]    reg_addr_i;
	logic [31:0]   reg_wdata_i, reg_rdata_o;
	logic [17:0]   imem_addr_o, imem_data_i, dmem_addr_o;
	logic          imem_rd_o, dmem_rd_o, condition_flag_o, unsupported_o;
	logic [8:0]    dmem_data_i, lf, a, b, c, x;
	cblme_sfr_t    sfr_o;
	cblme_status_t status_o;
	logic [21:0]   exp_q[$];
	logic [31:0]   rd_q[$];
	int            n_errors, samples_checked, ptr, q;

	cblme_core uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .imem_addr_o(imem_addr_o), .imem_rd_o(imem_rd_o),
		.imem_data_i(imem_data_i), .dmem_addr_o(dmem_addr_o), .dmem_rd_o(dmem_rd_o),
		.dmem_data_i(dmem_data_i), .sfr_o(sfr_o), .status_o(status_o),
		.condition_flag_o(condition_flag_o), .unsupported_o(unsupported_o));
	cblme_mem_model mem (.clk_sys_i(clk_sys_i), .imem_addr_i(imem_addr_o), .imem_rd_i(imem_rd_o),
		.imem_data_o(imem_data_i), .dmem_addr_i(dmem_addr_o), .dmem_rd_i(dmem_rd_o),
		.dmem_data_o(dmem_data_i));

	always #25 clk_sys_i = ~clk_sys_i;

	function automatic logic [8:0] rnd();
		lf = {lf[7:0], lf[8] ^ lf[4]};
		return lf;
	endfunction
	function automatic logic [17:0] fi(logic [4:0] op, logic [3:0] r, logic [8:0] imm);
		return {op, r, imm};
	endfunction
	function automatic logic [17:0] fr(logic [4:0] op, logic [3:0] d, logic [3:0] s,
			logic [4:0] fn);
		return {op, d, s, fn};
	endfunction
	task automatic emit(input logic [17:0] w);
		mem.rom[ptr] = w;
		ptr++;
	endtask
	task automatic show(input logic [3:0] r, input logic [17:0] e);
		emit(fr(`CBLME_OP_SPEC2, r, 4'h1, `CBLME_F2_WRITE_SPECIAL_REGISTER));
		exp_q.push_back({4'h1, e});
	endtask
	// The delay slot writes 1, the skipped word 2, so the shown value tells both apart.
	task automatic skip(input logic [17:0] w, input logic taken);
		emit(w);
		emit(fi(`CBLME_OP_MOVI, 4'h7, 9'h001));
		emit(fi(`CBLME_OP_MOVI, 4'h7, 9'h002));
		show(4'h7, taken ? 18'h00001 : 18'h00002);
	endtask
	task automatic err(input string m);
		$display("wrong value at %0t: %s", $time, m);
		n_errors++;
	endtask
	task automatic chk_sfr(input cblme_sfr_t s);
		samples_checked++;
		if (exp_q.size() == 0) err("unexpected special register write");
		else if ({s.idx, s.data} !== exp_q.pop_front()) err("special register data");
	endtask
	task automatic chk_bus(input logic [31:0] g);
		samples_checked++;
		if (g !== rd_q.pop_front()) err("register read data");
	endtask
	task automatic bus_wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= ad;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic bus_rd(input logic [3:0] ad, input logic [31:0] e);
		rd_q.push_back(e);
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= ad;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		rd_d <= reg_rd_i;
		if (rd_d === 1'b1) chk_bus(reg_rdata_o);
		if (sfr_o.wr === 1'b1) chk_sfr(sfr_o);
		if (unsupported_o === 1'b1) err("word outside the subset reported");
	end

	initial begin
		clk_sys_i = 1'b0;
		resetn_i = 1'b0;
		{reg_wr_i, reg_rd_i, rd_d} = 3'h0;
		reg_addr_i = 4'h0;
		reg_wdata_i = 32'h00000000;
		{n_errors, samples_checked, ptr} = 0;
		lf = 9'h042;
		for (int i = 0; i < 512; i++) begin
			mem.rom[i] = 18'h00000;
			mem.ram[i] = rnd();
		end
		a = rnd();
		b = rnd();
		c = rnd();
		emit(fi(`CBLME_OP_MOVI, 4'h1, a));
		show(4'h1, {9'h000, a});
		emit(fi(`CBLME_OP_LHI, 4'h2, b));
		show(4'h2, {b, 9'h000});
		emit(fr(`CBLME_OP_SPEC1, 4'h3, 4'h2, `CBLME_F1_MOV));
		show(4'h3, {b, 9'h000});
		emit(fr(`CBLME_OP_SPEC1, 4'h0, `CBLME_SEL_COND, `CBLME_F1_SBITS));
		emit(fi(`CBLME_OP_LHI, 4'h4, b));
		emit(fi(`CBLME_OP_IFADDUI, 4'h4, a));
		show(4'h4, {b, a});
		emit(fi(`CBLME_OP_ANDI, 4'h4, c));
		show(4'h4, {9'h000, a & c});
		emit(fr(`CBLME_OP_SPEC1, 4'h0, `CBLME_SEL_COND, `CBLME_F1_CBITS));
		emit(fi(`CBLME_OP_IFADDUI, 4'h4, 9'h1FF));
		show(4'h4, {9'h000, a & c});
		emit(fr(`CBLME_OP_SPEC1, 4'h0, `CBLME_SEL_COND, `CBLME_F1_SBITS));
		emit(fi(`CBLME_OP_IFSUBUI, 4'h4, c));
		show(4'h4, {9'h000, a & c} - {9'h000, c});
		emit(fi(`CBLME_OP_MOVI, 4'h6, 9'h000));
		emit(fi(`CBLME_OP_MOVI, 4'h5, 9'h001));
		skip(fi(`CBLME_OP_BEQZ, 4'h6, 9'h003), 1'b1);
		skip(fi(`CBLME_OP_BNEZ, 4'h6, 9'h003), 1'b0);
		skip(fi(`CBLME_OP_BNEZ, 4'h5, 9'h003), 1'b1);
		skip(fi(`CBLME_OP_BEQZ, 4'h5, 9'h003), 1'b0);
		for (int f = 1; f >= 0; f--) begin
			emit(fr(`CBLME_OP_SPEC1, 4'h0, `CBLME_SEL_COND,
				f ? `CBLME_F1_SBITS : `CBLME_F1_CBITS));
			skip({`CBLME_OP_BEQZC, 13'h0003}, f == 0);
			skip({`CBLME_OP_BNEZC, 13'h0003}, f == 1);
		end
		skip({`CBLME_OP_J, 13'h0003}, 1'b1);
		emit(fi(`CBLME_OP_MOVI, 4'h8, 9'(ptr + 4)));
		skip(fr(`CBLME_OP_SPEC2, 4'h0, 4'h8, `CBLME_F2_JR), 1'b1);
		emit(fi(`CBLME_OP_MOVI, 4'h8, 9'(ptr + 4)));
		q = ptr;
		skip(fr(`CBLME_OP_SPEC2, 4'h0, 4'h8, `CBLME_F2_JALR), 1'b1);
		show(4'hB, 18'(q + 2));
		emit(fi(`CBLME_OP_MOVI, 4'h9, 9'h040));
		emit({`CBLME_OP_L18, 4'hA, 4'h9, 5'h04});
		show(4'hA, {mem.ram[68], mem.ram[69]});
		emit({`CBLME_OP_L9, 4'hA, 4'h9, 5'h05});
		show(4'hA, {9'h000, mem.ram[69]});
		x = rnd();
		emit(fi(`CBLME_OP_MOVI, 4'h0, 9'h001));
		emit(fr(`CBLME_OP_SPEC2, 4'h0, `CBLME_SFR_STATE, `CBLME_F2_WRITE_SPECIAL_REGISTER));
		exp_q.push_back({`CBLME_SFR_STATE, 18'h00001});
		emit(fi(`CBLME_OP_MOVI, 4'hC, x));
		show(4'h4, {9'h000, x});
		emit(fi(`CBLME_OP_MOVI, 4'h0, 9'h000));
		emit(fr(`CBLME_OP_SPEC2, 4'h0, `CBLME_SFR_STATE, `CBLME_F2_WRITE_SPECIAL_REGISTER));
		exp_q.push_back({`CBLME_SFR_STATE, 18'h00000});
		emit(fr(`CBLME_OP_SPEC1, 4'h1, 4'h1, `CBLME_F1_MOV));
		for (int k = 0; k < 2; k++) begin
			x = rnd();
			emit(fi(`CBLME_OP_MOVI, 4'hC, x));
			emit(fi(`CBLME_OP_MOVI, 4'h8, 9'h190));
			q = ptr;
			emit(k ? fr(`CBLME_OP_SPEC2, 4'h0, 4'h8, `CBLME_F2_JALRS)
				: {`CBLME_OP_JALS, 13'(400 - q)});
			emit(fr(`CBLME_OP_SPEC1, 4'h1, 4'h1, `CBLME_F1_MOV));
			exp_q.push_back({4'h1, 9'h000, x});
			exp_q.push_back({4'h1, 18'(q + 2)});
			show(4'hC, {9'h000, x});
		end
		emit(fr(`CBLME_OP_SPEC1, 4'h0, `CBLME_SEL_HIADDR, `CBLME_F1_CBITS));
		emit(fr(`CBLME_OP_SPEC1, 4'h0, `CBLME_SEL_HIADDR, `CBLME_F1_SBITS));
		emit(fr(`CBLME_OP_SPEC1, 4'h0, `CBLME_SEL_IE, `CBLME_F1_SBITS));
		emit(fr(`CBLME_OP_SPEC1, 4'h0, `CBLME_SEL_IE, `CBLME_F1_CBITS));
		emit(fr(`CBLME_OP_SPEC1, 4'h0, `CBLME_SEL_COND, `CBLME_F1_SBITS));
		show(4'h1, {9'h000, a});
		emit({`CBLME_OP_J, 13'h0000});
		emit(fr(`CBLME_OP_SPEC1, 4'h1, 4'h1, `CBLME_F1_MOV));
		ptr = 400;
		// The subroutine reads the caller's r12 through the shifted window.
		emit(fr(`CBLME_OP_SPEC2, 4'h4, 4'h1, `CBLME_F2_WRITE_SPECIAL_REGISTER));
		emit(fr(`CBLME_OP_SPEC2, 4'hB, 4'h1, `CBLME_F2_WRITE_SPECIAL_REGISTER));
		emit(fr(`CBLME_OP_SPEC2, 4'h0, 4'hB, `CBLME_F2_JRS));
		emit(fr(`CBLME_OP_SPEC1, 4'h1, 4'h1, `CBLME_F1_MOV));
		repeat (3) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		bus_rd(`CBLME_REG_STATE, 32'h00000000);
		bus_rd(`CBLME_REG_PC, 32'h00000000);
		bus_wr(4'h6, 32'hFFFFFFFF);
		bus_rd(4'h6, 32'h00000000);
		$display("test reset and register port done");
		bus_wr(`CBLME_REG_CTRL, 32'h00000001);
		for (int i = 0; i < 5000 && exp_q.size() != 0; i++) @(posedge clk_sys_i);
		if (exp_q.size() != 0) begin
			err("program did not finish");
		end else begin
			$display("test program done");
			bus_rd(`CBLME_REG_STATE, 32'h00000080);
			bus_rd(`CBLME_REG_COND, 32'h00000001);
			repeat (3) @(posedge clk_sys_i);
			$display("test final state done");
		end
		close_out();
	end
endmodule // tb
